// >>> rtl/event_point_map.svh
// offsets, field positions, reset values and counts of the event-point unit
// How it works
// R1: each of four probe inputs can be required high or low for a match.
// R2: a probe set to don't care is ignored when matching.
// R3: a satisfied break event stops the user program; break is the default action.
// R4: a satisfied start-timer event starts the run timer; its value stays readable.
// R5: a satisfied stop-timer event halts the run timer and holds its value.
// R6: a break can wait a programmable 16-bit number of bus cycles after detection.
// R7: one delay counter exists, for break actions only.
// R8: break delay spans 0 to 65535 bus cycles and applies only with break selected.
// R9: each event has a 16-bit pass count from 0 to 65535.
// R10: the action fires only after the condition occurred pass-count times.
// R11: a trace-condition event takes no break or timer action and no delay.
// R12: arm and reset sequencing apply only when sequencing is enabled for the event.
// R13: satisfied state persists until program stop or reset; repeats do not retrigger.
// R14: with arm events, satisfiable only while one arm event is in the required state.
// R15: any configured reset event becoming satisfied resets the event and its pass count.
// R16: stopping the user program returns every event to unsatisfied.
// R17: a pass count of zero behaves like one.
// R18: delay counter loads on detection, counts down per bus cycle, breaks at zero.
`ifndef EVENT_POINT_MAP_SVH
`define EVENT_POINT_MAP_SVH

`define EVT_CHANNELS 8
`define CH_CFG_OFS 2'h0
`define CH_COUNT_OFS 2'h1
`define CH_RESET_OFS 2'h2
`define GLOBAL_SEL_BIT 7
`define SATISFIED_ADDR 8'h80
`define TIMER_ADDR 8'h84
`define IRQ_STATUS_ADDR 8'h88
`define IRQ_MASK_ADDR 8'h8C

`define CFG_EXT_INPUT_ONE_POS 0
`define CFG_EXT_INPUT_TWO_POS 2
`define CFG_EXT_INPUT_THREE_POS 4
`define CFG_EXT_INPUT_FOUR_POS 6
`define CFG_BREAK_BIT 8
`define CFG_START_BIT 9
`define CFG_STOP_BIT 10
`define CFG_SEQ_BIT 11
`define CFG_TRACE_BIT 12
`define CFG_ARM_INV_BIT 13
`define CFG_BUSMATCH_BIT 14
`define CFG_ARM_POS 16
`define CFG_RESET_VAL 32'h0000_0100
`define COUNT_PASS_POS 0
`define COUNT_DELAY_POS 16
`define COUNT_RESET_VAL 32'h0000_0000

`define IRQ_BREAK_BIT 0
`define IRQ_START_BIT 1
`define IRQ_STOP_BIT 2

`endif

// >>> rtl/event_point_pkg.sv
// types of the event-point unit
`include "event_point_map.svh"
package event_point_pkg;

  typedef enum logic [1:0] {
    PROBE_DONT_CARE = 2'b00,
    PROBE_HIGH = 2'b01,
    PROBE_LOW = 2'b10
  } probe_sel_type;

  typedef enum logic {
    DLY_IDLE = 1'b0,
    DLY_COUNT = 1'b1
  } delay_state_type;

  typedef struct packed {
    logic [3:0] probe_meta;
    logic [3:0] probe_sync;
    logic [`EVT_CHANNELS-1:0][31:0] cfg;
    logic [`EVT_CHANNELS-1:0][31:0] count_cfg;
    logic [`EVT_CHANNELS-1:0][7:0] reset_by;
    logic [`EVT_CHANNELS-1:0][15:0] pass;
    logic [`EVT_CHANNELS-1:0] sat;
    delay_state_type dly_state;
    logic [15:0] dly_count;
    logic timer_run;
    logic [31:0] timer;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic brk;
    logic irq;
    logic [31:0] rd_data;
  } unit_state_type;

endpackage

// >>> rtl/emulator_event_point_unit.sv
// event-point unit: probe matching, pass counts, sequencing, break delay and run timer
`timescale 1ns/1ps
`default_nettype none
`include "event_point_map.svh"
module emulator_event_point_unit
  import event_point_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_bus_cycle,
  input wire logic i_user_run,
  input wire logic [7:0] i_bus_match,
  input wire logic i_ext_input_one,
  input wire logic i_ext_input_two,
  input wire logic i_ext_input_three,
  input wire logic i_ext_input_four,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  output logic o_break,
  output logic o_timer_running,
  output logic [7:0] o_satisfied,
  output logic o_irq
);

  unit_state_type q;
  unit_state_type next_q;
  logic [7:0] fire;
  logic [7:0] cond;
  logic [7:0] armed;
  logic [7:0] start_fire;
  logic [7:0] stop_fire;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [7:0] trace_mask;
  logic [7:0] delay_fire;

  function automatic logic probe_ok(input logic [1:0] sel, input logic level);
    case (sel)
      PROBE_HIGH: probe_ok = level;
      PROBE_LOW: probe_ok = !level;
      default: probe_ok = 1'b1;
    endcase
  endfunction

  function automatic logic [15:0] need_count(input logic [15:0] pass_cfg);
    need_count = (pass_cfg == 16'h0000) ? 16'h0001 : pass_cfg; // [R17]
  endfunction

  always_comb begin
    next_q = q;
    fire = 8'h00;
    cond = 8'h00;
    armed = 8'h00;
    start_fire = 8'h00;
    stop_fire = 8'h00;
    irq_set = 3'h0;
    irq_clr = 3'h0;
    trace_mask = 8'h00;
    delay_fire = 8'h00;
    next_q.probe_meta = {i_ext_input_four, i_ext_input_three, i_ext_input_two, i_ext_input_one};
    next_q.probe_sync = q.probe_meta;
    next_q.brk = 1'b0;

    // detection and pass counting
    for (int ch = 0; ch < `EVT_CHANNELS; ch++) begin
      trace_mask[ch] = q.cfg[ch][`CFG_TRACE_BIT];
      cond[ch] = probe_ok(q.cfg[ch][`CFG_EXT_INPUT_ONE_POS +: 2], q.probe_sync[0]) && // [R1] [R2]
                 probe_ok(q.cfg[ch][`CFG_EXT_INPUT_TWO_POS +: 2], q.probe_sync[1]) &&
                 probe_ok(q.cfg[ch][`CFG_EXT_INPUT_THREE_POS +: 2], q.probe_sync[2]) &&
                 probe_ok(q.cfg[ch][`CFG_EXT_INPUT_FOUR_POS +: 2], q.probe_sync[3]) &&
                 (!q.cfg[ch][`CFG_BUSMATCH_BIT] || i_bus_match[ch]);
      armed[ch] = !q.cfg[ch][`CFG_SEQ_BIT] || // [R12]
                  (q.cfg[ch][`CFG_ARM_POS +: 8] == 8'h00) ||
                  (|(q.cfg[ch][`CFG_ARM_POS +: 8] &
                     (q.cfg[ch][`CFG_ARM_INV_BIT] ? ~q.sat : q.sat))); // [R14]
      if (i_bus_cycle && i_user_run && cond[ch] && armed[ch] && !q.sat[ch]) begin // [R13]
        if (({1'b0, q.pass[ch]} + 17'h00001) >=
            {1'b0, need_count(q.count_cfg[ch][`COUNT_PASS_POS +: 16])}) begin // [R9] [R10]
          fire[ch] = 1'b1;
          next_q.sat[ch] = 1'b1;
          next_q.pass[ch] = 16'h0000;
        end else begin
          next_q.pass[ch] = q.pass[ch] + 16'h0001;
        end
      end
    end

    // reset events
    for (int ch = 0; ch < `EVT_CHANNELS; ch++) begin
      if (q.cfg[ch][`CFG_SEQ_BIT] && (|(q.reset_by[ch] & fire))) begin // [R15] [R12]
        next_q.sat[ch] = 1'b0;
        next_q.pass[ch] = 16'h0000;
      end
    end

    // delay counter steps on bus cycles
    if (q.dly_state == DLY_COUNT && i_bus_cycle) begin
      next_q.dly_count = q.dly_count - 16'h0001; // [R18]
      if (q.dly_count == 16'h0001) begin
        next_q.brk = 1'b1;
        next_q.dly_state = DLY_IDLE;
      end
    end

    // actions; trace-condition events act on nothing
    for (int ch = 0; ch < `EVT_CHANNELS; ch++) begin
      if (fire[ch] && !q.cfg[ch][`CFG_TRACE_BIT]) begin // [R11]
        if (q.cfg[ch][`CFG_BREAK_BIT]) begin // [R3] [R8]
          if (q.count_cfg[ch][`COUNT_DELAY_POS +: 16] == 16'h0000) begin
            next_q.brk = 1'b1; // [R3]
          end else begin
            next_q.dly_state = DLY_COUNT; // [R6] [R7]
            delay_fire[ch] = 1'b1;
            next_q.dly_count = q.count_cfg[ch][`COUNT_DELAY_POS +: 16];
          end
        end
        start_fire[ch] = q.cfg[ch][`CFG_START_BIT];
        stop_fire[ch] = q.cfg[ch][`CFG_STOP_BIT];
      end
    end
    if (|start_fire) begin
      next_q.timer_run = 1'b1; // [R4]
    end
    if (|stop_fire) begin
      next_q.timer_run = 1'b0; // [R5]
    end
    if (q.timer_run && i_user_run) begin
      next_q.timer = q.timer + 32'h0000_0001;
    end

    if (!i_user_run) begin
      next_q.sat = 8'h00; // [R16]
      next_q.pass = '0;
      next_q.dly_state = DLY_IDLE;
    end

    irq_set[`IRQ_BREAK_BIT] = next_q.brk;
    irq_set[`IRQ_START_BIT] = |start_fire;
    irq_set[`IRQ_STOP_BIT] = |stop_fire;

    // register writes
    if (i_wr) begin
      if (!i_addr[`GLOBAL_SEL_BIT]) begin
        case (i_addr[3:2])
          `CH_CFG_OFS: next_q.cfg[i_addr[6:4]] = i_wr_data;
          `CH_COUNT_OFS: next_q.count_cfg[i_addr[6:4]] = i_wr_data;
          `CH_RESET_OFS: next_q.reset_by[i_addr[6:4]] = i_wr_data[7:0];
          default: ;
        endcase
      end else begin
        case (i_addr)
          `TIMER_ADDR: next_q.timer = i_wr_data;
          `IRQ_STATUS_ADDR: irq_clr = i_wr_data[2:0];
          `IRQ_MASK_ADDR: next_q.irq_mask = i_wr_data[2:0];
          default: ;
        endcase
      end
    end
    // a new event wins over a clear in the same cycle
    next_q.irq_status = (q.irq_status & ~irq_clr) | irq_set;
    next_q.irq = |(next_q.irq_status & next_q.irq_mask);

    // register reads, unmapped addresses answer zero
    next_q.rd_data = 32'h0000_0000;
    if (i_rd) begin
      if (!i_addr[`GLOBAL_SEL_BIT]) begin
        case (i_addr[3:2])
          `CH_CFG_OFS: next_q.rd_data = q.cfg[i_addr[6:4]];
          `CH_COUNT_OFS: next_q.rd_data = q.count_cfg[i_addr[6:4]];
          `CH_RESET_OFS: next_q.rd_data = {24'h00_0000, q.reset_by[i_addr[6:4]]};
          default: next_q.rd_data = 32'h0000_0000;
        endcase
      end else begin
        case (i_addr)
          `SATISFIED_ADDR: next_q.rd_data = {24'h00_0000, q.sat};
          `TIMER_ADDR: next_q.rd_data = q.timer; // [R4] [R5]
          `IRQ_STATUS_ADDR: next_q.rd_data = {29'h0000_0000, q.irq_status};
          `IRQ_MASK_ADDR: next_q.rd_data = {29'h0000_0000, q.irq_mask};
          default: next_q.rd_data = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q.probe_meta <= 4'h0;
      q.probe_sync <= 4'h0;
      for (int ch = 0; ch < `EVT_CHANNELS; ch++) begin
        q.cfg[ch] <= `CFG_RESET_VAL; // [R3]
        q.count_cfg[ch] <= `COUNT_RESET_VAL;
        q.reset_by[ch] <= 8'h00;
        q.pass[ch] <= 16'h0000;
      end
      q.sat <= 8'h00;
      q.dly_state <= DLY_IDLE;
      q.dly_count <= 16'h0000;
      q.timer_run <= 1'b0;
      q.timer <= 32'h0000_0000;
      q.irq_status <= 3'h0;
      q.irq_mask <= 3'h0;
      q.brk <= 1'b0;
      q.irq <= 1'b0;
      q.rd_data <= 32'h0000_0000;
    end else begin
      q <= next_q;
    end
  end

  assign o_rd_data = q.rd_data;
  assign o_break = q.brk;
  assign o_timer_running = q.timer_run;
  assign o_satisfied = q.sat;
  assign o_irq = q.irq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_STOP_CLEARS: assert property (!i_user_run |=> q.sat == 8'h00) // [R16]
    else $error("events still satisfied after program stop");
  AST_SAT_STICKY: assert property ( // [R13]
    (q.sat[0] && i_user_run && !(q.cfg[0][`CFG_SEQ_BIT] && |(q.reset_by[0] & fire)))
    |=> q.sat[0])
    else $error("satisfied state dropped without stop or reset");
  AST_SAT_ON_BUS: assert property ($rose(q.sat[0]) |-> $past(i_bus_cycle) && $past(i_user_run)) // [R10]
    else $error("event satisfied outside a bus cycle");
  AST_ZERO_DELAY: assert property ( // [R6]
    (fire[0] && q.cfg[0][`CFG_BREAK_BIT] && !q.cfg[0][`CFG_TRACE_BIT] &&
     q.count_cfg[0][`COUNT_DELAY_POS +: 16] == 16'h0000) |=> o_break)
    else $error("zero-delay break not taken next cycle");
  AST_DELAY_END: assert property ( // [R18]
    (q.dly_state == DLY_COUNT && q.dly_count == 16'h0001 && i_bus_cycle && fire == 8'h00)
    |=> o_break ##1 (!o_break || $past(|fire)))
    else $error("delayed break not a one-cycle pulse at zero");
  AST_TIMER_START: assert property ($rose(q.timer_run) |-> $past(|start_fire)) // [R4]
    else $error("run timer started without a start event");
  AST_TIMER_HOLD: assert property ((!q.timer_run && !i_wr) |=> $stable(q.timer)) // [R5]
    else $error("stopped run timer changed");
  AST_TRACE_QUIET: assert property ( // [R11]
    (fire != 8'h00 && (fire & ~trace_mask) == 8'h00 && q.dly_state == DLY_IDLE) |=> !o_break)
    else $error("trace-condition event caused a break");
  AST_PROBE_HIGH: assert property ( // [R1]
    (fire[0] && q.cfg[0][`CFG_EXT_INPUT_ONE_POS +: 2] == PROBE_HIGH) |-> q.probe_sync[0])
    else $error("event fired with required-high probe low");
  AST_BREAK_IRQ: assert property (o_break |-> q.irq_status[`IRQ_BREAK_BIT]) // [R3]
    else $error("break did not set its status bit");
  AST_BREAK_CAUSE: assert property (o_break |-> $past(|fire) || $past(q.dly_state == DLY_COUNT)) // [R3]
    else $error("break without an event or a running delay");

  // probe matching
  AST_PROBE_LOW: assert property ( // [R1]
    (fire[0] && q.cfg[0][`CFG_EXT_INPUT_ONE_POS +: 2] == PROBE_LOW)
    |-> !q.probe_sync[0])
    else $error("event fired with required-low probe high");
  AST_PROBE_IGNORED: assert property ( // [R2]
    (q.cfg[0][`CFG_EXT_INPUT_ONE_POS +: 8] == 8'h00 && !q.cfg[0][`CFG_BUSMATCH_BIT])
    |-> cond[0])
    else $error("don't-care probes blocked a match");

  // pass counting and sticky state
  AST_FIRST_MATCH: assert property ( // [R17]
    (q.count_cfg[0][`COUNT_PASS_POS +: 16] <= 16'h0001 && i_bus_cycle && i_user_run &&
     cond[0] && armed[0] && !q.sat[0] && !(q.cfg[0][`CFG_SEQ_BIT] && |(q.reset_by[0] & fire)))
    |=> q.sat[0])
    else $error("pass count zero or one did not fire on first match");
  AST_PASS_QUIET: assert property ( // [R10]
    (i_user_run && !i_bus_cycle) |=> $stable(q.pass) && $stable(q.sat))
    else $error("pass count or satisfied state moved outside a bus cycle");
  AST_NO_RETRIGGER: assert property ( // [R13]
    (q.sat[0] && (fire & 8'hFE) == 8'h00 && q.dly_state == DLY_IDLE)
    |=> !o_break)
    else $error("satisfied event retriggered its break");

  // sequencing
  AST_UNARMED: assert property ( // [R14]
    (q.cfg[1][`CFG_SEQ_BIT] && !q.cfg[1][`CFG_ARM_INV_BIT] &&
     q.cfg[1][`CFG_ARM_POS +: 8] != 8'h00 && (q.cfg[1][`CFG_ARM_POS +: 8] & q.sat) == 8'h00)
    |=> !$rose(q.sat[1]))
    else $error("event satisfied while none of its arm events was");
  AST_RESET_EVENT: assert property ( // [R15]
    (q.cfg[1][`CFG_SEQ_BIT] && |(q.reset_by[1] & fire))
    |=> !q.sat[1] && q.pass[1] == 16'h0000)
    else $error("reset event left its target satisfied or counting");
  AST_SEQ_OFF: assert property ( // [R12]
    (!q.cfg[1][`CFG_SEQ_BIT] && q.sat[1] && i_user_run) |=> q.sat[1])
    else $error("event without sequencing was reset by another event");

  // break delay
  AST_DELAY_LOAD: assert property ( // [R6] [R18]
    (delay_fire != 8'h00) |=> q.dly_state == DLY_COUNT && q.dly_count != 16'h0000)
    else $error("delayed break did not start the delay counter");
  AST_DELAY_STEP: assert property ( // [R7] [R18]
    (q.dly_state == DLY_COUNT && i_user_run && delay_fire == 8'h00)
    |=> q.dly_count == ($past(i_bus_cycle) ? $past(q.dly_count) - 16'h0001 : $past(q.dly_count)))
    else $error("delay counter did not step once per bus cycle");
  AST_DELAY_BREAK_ONLY: assert property ( // [R8]
    (fire != 8'h00 && delay_fire == 8'h00 && q.dly_state == DLY_IDLE)
    |=> q.dly_state == DLY_IDLE)
    else $error("delay counter started without a delayed break");

  // run timer
  AST_START_RUNS: assert property ( // [R4]
    (start_fire != 8'h00 && stop_fire == 8'h00) |=> o_timer_running)
    else $error("start event did not start the run timer");
  AST_STOP_HALTS: assert property ((stop_fire != 8'h00) |=> !o_timer_running) // [R5]
    else $error("stop event did not halt the run timer");
  AST_TIMER_STEP: assert property ( // [R4]
    (q.timer_run && i_user_run && !i_wr) |=> q.timer == $past(q.timer) + 32'h0000_0001)
    else $error("running timer did not advance by one");
  AST_TRACE_TIMER: assert property ( // [R11]
    (fire != 8'h00 && (fire & ~trace_mask) == 8'h00) |=> $stable(q.timer_run))
    else $error("trace-condition event moved the run timer");

  // program stop and register port
  AST_STOP_IDLE: assert property ( // [R16]
    !i_user_run |=> q.pass == '0 && q.dly_state == DLY_IDLE)
    else $error("pass counts or delay survived program stop");
  AST_RD_TIMER: assert property ( // [R4]
    (i_rd && i_addr == `TIMER_ADDR) |=> o_rd_data == $past(q.timer))
    else $error("timer read returned a wrong value");
  AST_RD_SAT: assert property ( // [R13]
    (i_rd && i_addr == `SATISFIED_ADDR) |=> o_rd_data == {24'h00_0000, $past(q.sat)})
    else $error("satisfied read returned a wrong value");
  AST_RD_IDLE: assert property (!i_rd |=> o_rd_data == 32'h0000_0000)
    else $error("read data not zero outside the read answer cycle");
  AST_IRQ_LEVEL: assert property (o_irq == |(q.irq_status & q.irq_mask))
    else $error("interrupt output differs from unmasked status");
  AST_STATUS_STICKY: assert property (
    (q.irq_status[`IRQ_BREAK_BIT] && !(i_wr && i_addr == `IRQ_STATUS_ADDR && i_wr_data[0]))
    |=> q.irq_status[`IRQ_BREAK_BIT])
    else $error("break status bit dropped without a clear");

  CVR_BREAK: cover property (fire[0] ##1 o_break);
  CVR_DELAYED: cover property (q.dly_state == DLY_COUNT ##[1:20] o_break);
  CVR_TIMER: cover property ($rose(q.timer_run) ##[1:50] $fell(q.timer_run));
  CVR_RESET_EVT: cover property ($fell(q.sat[1]) && i_user_run);
  CVR_ARMED: cover property (q.cfg[1][`CFG_SEQ_BIT] && $rose(q.sat[1]));

endmodule
`default_nettype wire

// >>> dv/target_bus_model.sv
// target bus model: issues bus cycles with their per-channel match results
`timescale 1ns/1ps
`default_nettype none
module target_bus_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_req,
  input wire logic [7:0] i_match,
  output logic o_bus_cycle,
  output logic [7:0] o_bus_match
);
  // outside a bus cycle the match lines carry stale, inverted values
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_cycle <= 1'h0;
      o_bus_match <= 8'h00;
    end else begin
      o_bus_cycle <= i_req;
      o_bus_match <= i_req ? i_match : ~o_bus_match;
    end
  end
endmodule
`default_nettype wire

// >>> dv/test_emulator_event_point_unit.sv
// self-checking bench of the event-point unit
`timescale 1ns/1ps
`default_nettype none
module test_emulator_event_point_unit;
  logic clk, rst, req, run, wr, rd, bcyc, brk, trun, irq;
  logic [7:0] match, bmatch, addr, sat;
  logic [3:0] pr;
  logic [31:0] wdata, rdata, t1, t2;
  int fail_count, checks_done, brk_n, b0, n, lvl;

  target_bus_model target_bus_model_i (.i_clk(clk), .i_rst(rst), .i_req(req),
    .i_match(match), .o_bus_cycle(bcyc), .o_bus_match(bmatch));
  emulator_event_point_unit emulator_event_point_unit_i (.i_clk(clk), .i_rst(rst),
    .i_bus_cycle(bcyc), .i_user_run(run), .i_bus_match(bmatch),
    .i_ext_input_one(pr[0]), .i_ext_input_two(pr[1]), .i_ext_input_three(pr[2]),
    .i_ext_input_four(pr[3]), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd),
    .o_rd_data(rdata), .o_break(brk), .o_timer_running(trun), .o_satisfied(sat),
    .o_irq(irq));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (brk === 1'h1) brk_n++;

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  // every channel also needs its bus match line, so idle channels stay quiet
  task cfg(input int ch, input logic [31:0] v);
    wr_reg(8'(ch * 16), v | 32'h0000_4000);
  endtask
  task fire(input logic [7:0] m);
    @(posedge clk);
    req <= 1'h1;
    match <= m;
    @(posedge clk);
    req <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task restart;
    @(posedge clk);
    run <= 1'h0;
    @(posedge clk);
    run <= 1'h1;
    #1;
    chk("satisfied", 0, sat);
  endtask

  initial begin
    rst = 1'h1;
    run = 1'h0;
    req = 1'h0;
    wr = 1'h0;
    rd = 1'h0;
    match = 8'h00;
    addr = 8'h00;
    wdata = 32'h0;
    pr = 4'h0;
    void'($urandom(28));
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    run <= 1'h1;
    rd_reg(8'h00, t1);
    chk("cfg0 reset", 32'h100, t1);
    rd_reg(8'h0C, t1);
    chk("unmapped", 0, t1);
    for (int c = 0; c < 8; c++) cfg(c, 0);
    for (int i = 0; i < 8; i++) begin
      lvl = $urandom % 2;
      t2 = $urandom;
      t2[i / 2] = lvl[0];
      pr <= t2[3:0];
      cfg(0, 32'h100 | ((i % 2 + 1) << (2 * (i / 2))));
      restart();
      repeat (4) @(posedge clk);
      fire(8'h01);
      chk("probe match", (i % 2) ? !lvl : lvl, sat[0]);
    end
    cfg(0, 0);
    wr_reg(8'h88, 32'h7);
    wr_reg(8'h8C, 32'h1);
    cfg(1, 32'h100);
    for (int r = 0; r < 2; r++) begin
      n = r ? $urandom % 5 + 2 : 0;
      wr_reg(8'h14, 32'(n));
      restart();
      b0 = brk_n;
      for (int k = 1; k < 8; k++) begin
        fire(8'h02);
        chk("pass sat", k >= (n ? n : 1), sat[1]);
        chk("pass break", k >= (n ? n : 1), brk_n - b0);
      end
    end
    chk("irq", 1, irq);
    wr_reg(8'h88, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("irq clear", 0, irq);
    cfg(1, 0);
    cfg(2, 32'h100);
    wr_reg(8'h24, 32'h0003_0000);
    restart();
    b0 = brk_n;
    for (int k = 0; k < 4; k++) begin
      fire(8'h04);
      chk("delayed break", k == 3, brk_n - b0);
    end
    cfg(2, 32'h1100);
    restart();
    b0 = brk_n;
    repeat (4) fire(8'h04);
    chk("trace break", 0, brk_n - b0);
    cfg(2, 0);
    cfg(3, 32'h200);
    cfg(4, 32'h400);
    wr_reg(8'h34, 32'h0005_0000);
    restart();
    b0 = brk_n;
    fire(8'h08);
    chk("timer run", 1, trun);
    rd_reg(8'h84, t1);
    rd_reg(8'h84, t2);
    chk("timer counts", 1, t2 > t1);
    fire(8'h10);
    chk("timer stop", 0, trun);
    rd_reg(8'h84, t1);
    rd_reg(8'h84, t2);
    chk("timer held", t1, t2);
    chk("no delay break", 0, brk_n - b0);
    cfg(3, 0);
    cfg(4, 0);
    wr_reg(8'h14, 32'h0);
    cfg(1, 32'h1_0900);
    wr_reg(8'h18, 32'h4);
    restart();
    fire(8'h02);
    chk("unarmed", 0, sat);
    fire(8'h01);
    fire(8'h02);
    chk("armed", 8'h03, sat);
    fire(8'h04);
    chk("reset event", 8'h05, sat);
    rd_reg(8'h80, t1);
    chk("sat reg", 32'h05, t1);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
